// *** core/tpm_defines.svh ***
/*
  Constants for the test pattern and line mirror block: pattern codes,
  mirror codes and reset values. Assumes inclusion by bare name.
*/
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// ----------------------------------------
// Pattern source codes
// ----------------------------------------
`define PAT_OFF 3'h0
`define PAT_HRAMP 3'h1
`define PAT_VRAMP 3'h2
`define PAT_DRAMP 3'h3
`define PAT_PURITY 3'h4

// ----------------------------------------
// Mirror codes and reset values
// ----------------------------------------
`define MIRROR_OFF 1'b0
`define MIRROR_ON 1'b1
`define GREY_RESET 0

`endif

// *** core/tpm_pkg.sv ***
/*
  Types for the test pattern and line mirror block.
  Assumes the pixel width fits in 16 bits.
*/
package tpm_pkg;
  // Pixel beat with line and frame markers
  typedef struct packed {
    logic [15:0] data;
    logic sol;
    logic eol;
    logic sof;
  } pixel_beat_t;
  // Mirror engine states
  typedef enum logic [1:0] {FILL, DRAIN} mirror_state_t;
endpackage

// *** core/test_pattern_mirror.sv ***
/*
  Pixel-path block: pattern injection after conversion, then line mirror
  and a two-entry output buffer. Assumes a same-clock upstream stream with
  start-of-line, end-of-line and start-of-frame markers on each beat.
*/
`timescale 1ns/1ps
`include "tpm_defines.svh"
module test_pattern_mirror import tpm_pkg::*; #(
  parameter int PIX_W = 8,
  parameter int MAX_LINE = 1024
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Settings, static during a frame
  input wire logic [2:0] patternSourceSelect,
  input wire logic lineMirrorSelect,
  // Sensor pixel stream in
  input wire pixel_beat_t adcBeat,
  input wire logic adcValid,
  output logic adcReady,
  // Pixel stream out to the pipeline
  output pixel_beat_t outBeat,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(MAX_LINE);

  // ----------------------------------------
  // Pattern generator
  // ----------------------------------------
  logic [PIX_W-1:0] hCnt_ff, nxt_hCnt;     // Pixel ramp
  logic [PIX_W-1:0] vCnt_ff, nxt_vCnt;     // Line ramp
  logic [PIX_W-1:0] fCnt_ff, nxt_fCnt;     // Frame step
  logic [PIX_W-1:0] patPix;                // Generated grey value
  logic [PIX_W-1:0] frmVal;                // Frame value for this beat
  logic inFire;                            // Beat accepted
  pixel_beat_t srcBeat;                    // Beat after injection

  // Computes the grey value for the current beat position
  always_comb begin
    nxt_hCnt = hCnt_ff;
    nxt_vCnt = vCnt_ff;
    nxt_fCnt = fCnt_ff;
    // Counters at the beat's own position; markers restart them
    if (adcBeat.sof) begin
      nxt_vCnt = '0;
    end else if (adcBeat.sol) begin
      nxt_vCnt = vCnt_ff + 1'b1;
    end
    if (adcBeat.sol) begin
      nxt_hCnt = '0;
    end
    // first beat of a frame already carries the stepped value, so
    // the whole frame, its first pixel too, shows one frame value
    frmVal = adcBeat.sof ? PIX_W'(fCnt_ff + 1'b1) : fCnt_ff;
    case (patternSourceSelect)
      `PAT_HRAMP: patPix = nxt_hCnt;
      `PAT_VRAMP: patPix = nxt_vCnt;
      `PAT_DRAMP: patPix = PIX_W'(nxt_hCnt + nxt_vCnt + frmVal);
      `PAT_PURITY: patPix = frmVal;
      default: patPix = '0;
    endcase
    // Advance for the next beat
    if (inFire) begin
      nxt_hCnt = nxt_hCnt + 1'b1;
    end else begin
      nxt_hCnt = hCnt_ff;
      nxt_vCnt = vCnt_ff;
    end
    if (inFire && adcBeat.sof) begin
      nxt_fCnt = frmVal;
    end
  end

  // Registers pattern counters
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hCnt_ff <= '0;
      vCnt_ff <= '0;
      fCnt_ff <= '0;
    end else begin
      hCnt_ff <= nxt_hCnt;
      vCnt_ff <= nxt_vCnt;
      fCnt_ff <= nxt_fCnt;
    end
  end

  always_comb begin
    srcBeat = adcBeat;
    if (patternSourceSelect != `PAT_OFF) begin
      srcBeat.data = 16'(patPix);
    end
  end

  // ----------------------------------------
  // Line mirror
  // ----------------------------------------
  // Two line memories ping-pong so one fills while the other drains,
  // keeping full throughput at the cost of one line of latency.
  logic [15:0] lineMem [2][MAX_LINE];
  logic flagMem [2];                       // Frame marker per line
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr;      // Fill position
  logic wrBank_ff, nxt_wrBank;             // Bank being filled
  logic [AW:0] len_ff [2];                 // Stored line lengths
  logic full_ff [2];                       // Bank holds a line
  logic nxt_full [2];                      // Bank holds a line next cycle
  logic [AW-1:0] rdPtr_ff, nxt_rdPtr;      // Drain position
  logic rdBank_ff, nxt_rdBank;             // Bank being drained
  logic midFire;                           // Beat into buffer
  logic midValid;                          // Mirror output valid
  logic midReady;                          // Buffer has room
  logic mirrorOn_ff;                       // Latched per line
  pixel_beat_t midBeat;                    // Mirror output beat
  logic [AW-1:0] rdIdx;                    // Memory read index
  logic [AW:0] rdLen;                      // Length of drained line

  assign rdLen = len_ff[rdBank_ff];
  assign rdIdx = (mirrorOn_ff == `MIRROR_ON) ? AW'(rdLen - 1'b1 - (AW+1)'(rdPtr_ff)) : rdPtr_ff;
  assign inFire = adcValid && adcReady;
  assign midValid = full_ff[rdBank_ff];
  assign midFire = midValid && midReady;

  // Builds the outgoing beat from the drained bank
  always_comb begin
    midBeat.data = lineMem[rdBank_ff][rdIdx];
    midBeat.sol = (rdPtr_ff == '0);
    midBeat.eol = ((AW+1)'(rdPtr_ff) == rdLen - 1'b1);
    midBeat.sof = flagMem[rdBank_ff] && (rdPtr_ff == '0);
  end

  // Next fill and drain positions
  always_comb begin
    nxt_wrPtr = wrPtr_ff;
    nxt_wrBank = wrBank_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_rdBank = rdBank_ff;
    for (int b = 0; b < 2; b++) begin
      nxt_full[b] = full_ff[b];
    end
    if (inFire) begin
      nxt_wrPtr = srcBeat.eol ? '0 : wrPtr_ff + 1'b1;
      nxt_wrBank = srcBeat.eol ? !wrBank_ff : wrBank_ff;
    end
    // A line's last beat marks its bank full
    if (inFire && srcBeat.eol) begin
      nxt_full[wrBank_ff] = 1'b1;
    end
    if (midFire) begin
      nxt_rdPtr = midBeat.eol ? '0 : rdPtr_ff + 1'b1;
      nxt_rdBank = midBeat.eol ? !rdBank_ff : rdBank_ff;
    end
    // Draining the last beat frees the bank
    if (midFire && midBeat.eol) begin
      nxt_full[rdBank_ff] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (inFire) begin
      lineMem[wrBank_ff][wrPtr_ff] <= srcBeat.data;
      if (srcBeat.sol) begin
        flagMem[wrBank_ff] <= srcBeat.sof;
      end
    end
    if (!rst_n) begin
      wrPtr_ff <= '0;
      wrBank_ff <= 1'b0;
      rdPtr_ff <= '0;
      rdBank_ff <= 1'b0;
      mirrorOn_ff <= `MIRROR_OFF;
      adcReady <= 1'b1;
      for (int b = 0; b < 2; b++) begin
        full_ff[b] <= 1'b0;
        len_ff[b] <= '0;
      end
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      wrBank_ff <= nxt_wrBank;
      rdPtr_ff <= nxt_rdPtr;
      rdBank_ff <= nxt_rdBank;
      // Mirror setting only changes between lines
      if (!midValid || (midFire && midBeat.eol)) begin
        mirrorOn_ff <= lineMirrorSelect;
      end
      if (inFire && srcBeat.eol) begin
        len_ff[wrBank_ff] <= (AW+1)'(wrPtr_ff) + 1'b1;
      end
      for (int b = 0; b < 2; b++) begin
        full_ff[b] <= nxt_full[b];
      end
      // Ready as a flop: the bank the next beat lands in must be empty
      adcReady <= !nxt_full[nxt_wrBank];
    end
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  pixel_beat_t buf_ff [2];                 // Entries
  logic [1:0] cnt_ff, nxt_cnt;             // Occupancy
  logic head_ff, nxt_head;                 // Read slot
  logic outFire;                           // Downstream took beat

  assign midReady = (cnt_ff != 2'd2);
  assign outFire = outValid && outReady;

  // Occupancy and head update
  always_comb begin
    nxt_cnt = cnt_ff + {1'b0, midFire} - {1'b0, outFire};
    nxt_head = outFire ? !head_ff : head_ff;
  end

  // Buffer storage and registered outputs
  always_ff @(posedge clk_sys) begin
    if (midFire) begin
      buf_ff[head_ff ^ cnt_ff[0] ^ cnt_ff[1] ^ outFire ^ outFire] <= midBeat;
    end
    if (!rst_n) begin
      cnt_ff <= '0;
      head_ff <= 1'b0;
      outValid <= 1'b0;
      outBeat <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      head_ff <= nxt_head;
      outValid <= (nxt_cnt != 2'd0);
      if (nxt_cnt != 2'd0) begin
        if (nxt_head == head_ff ^ cnt_ff[1] && cnt_ff == 2'd0) begin
          outBeat <= midBeat;
        end else if (outFire && cnt_ff == 2'd1) begin
          outBeat <= midBeat;
        end else begin
          outBeat <= buf_ff[nxt_head];
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_hramp_line_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inFire && adcBeat.sol && patternSourceSelect == `PAT_HRAMP |-> srcBeat.data == 16'h0000)
    else $error("Horizontal ramp did not restart at zero");
  a_hramp_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inFire && !adcBeat.sol && patternSourceSelect == `PAT_HRAMP && $stable(patternSourceSelect)
    |-> srcBeat.data == 16'(hCnt_ff))
    else $error("Horizontal ramp did not step by one");
  a_purity_flat: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inFire && !adcBeat.sof && patternSourceSelect == `PAT_PURITY |-> srcBeat.data == 16'(fCnt_ff))
    else $error("Purity pixel differs from frame value");
  a_purity_frame_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inFire && adcBeat.sof && patternSourceSelect == `PAT_PURITY |-> srcBeat.data == 16'(PIX_W'(fCnt_ff + 1'b1)))
    else $error("Purity frame did not start one value up");
  a_frame_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inFire && adcBeat.sof && adcBeat.sol |=> fCnt_ff == PIX_W'($past(fCnt_ff) + 1'b1))
    else $error("Frame value did not advance by one");
  a_passthrough_video: assert property (@(posedge clk_sys) disable iff (!rst_n)
    patternSourceSelect == `PAT_OFF |-> srcBeat.data == adcBeat.data)
    else $error("Sensor video altered with patterns off");
  a_vramp_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inFire && adcBeat.sol && !adcBeat.sof && patternSourceSelect == `PAT_VRAMP
    |-> srcBeat.data == 16'(PIX_W'(vCnt_ff + 1'b1)))
    else $error("Vertical ramp did not step per line");
  a_mirror_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    midValid && mirrorOn_ff && midBeat.sol |-> (AW+1)'(rdIdx) == rdLen - 1'b1)
    else $error("Mirrored line does not start at last pixel");
  a_no_stall_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    midFire && midBeat.eol |=> adcReady)
    else $error("Mirror stalled input after draining a line");
endmodule

// *** dv/pipe_sink.sv ***
/*
  Downstream pipeline model: takes output beats into mem.
  Assumes one clock; the bench reads mem and cnt.
*/
`timescale 1ns/1ps
module pipe_sink import tpm_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pacing from the bench
  input wire logic stall,
  input wire logic slow,
  // Stream from the block
  input wire pixel_beat_t outBeat,
  input wire logic outValid,
  output logic outReady
);
  pixel_beat_t mem [0:255]; // Beats taken
  int cnt; // Count of beats taken
  logic tick_ff; // Half-rate pacing
  // Ready moves just after an edge, never on the opposite one
  always_ff @(posedge clk_sys) begin
    tick_ff <= rst_n ? !tick_ff : 1'b0;
    outReady <= rst_n && !stall && !(slow && tick_ff);
    if (!rst_n) begin
      cnt <= 0;
    end else if (outValid && outReady) begin
      mem[cnt[7:0]] <= outBeat;
      cnt <= cnt + 1;
    end
  end
endmodule

// *** dv/test_pattern_mirror_tb_top.sv ***
/*
  Self-checking bench: drives pixel lines, judges the sink's capture.
  Assumes PIX_W 3 so ramps wrap inside short lines.
*/
`timescale 1ns/1ps
`include "tpm_defines.svh"
module test_pattern_mirror_tb_top import tpm_pkg::*;;
  localparam logic [15:0] MSK = 16'h0007; // Pattern bits
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] patSel = `PAT_OFF;
  logic mirSel = `MIRROR_OFF;
  pixel_beat_t adcBeat = '0;
  logic adcValid = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic adcReady, outValid, outReady;
  pixel_beat_t outBeat;
  int n_mismatch = 0;
  int samples_checked = 0;
  int base; // Sink count at test start
  int cyc = 0; // Free cycle count
  test_pattern_mirror #(.PIX_W(3), .MAX_LINE(16)) test_pattern_mirror_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .patternSourceSelect(patSel), .lineMirrorSelect(mirSel), .adcBeat(adcBeat), .adcValid(adcValid),
    .adcReady(adcReady), .outBeat(outBeat), .outValid(outValid), .outReady(outReady));
  pipe_sink pipe_sink_i (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .slow(slow),
    .outBeat(outBeat), .outValid(outValid), .outReady(outReady));
  initial begin
    forever #4 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) cyc++;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic pixel_beat_t got(input int k);
    return pipe_sink_i.mem[8'(base + k)];
  endfunction
  // One line, held until each beat is taken
  task automatic send_line(input int n, input logic fst, input logic [15:0] d0);
    for (int i = 0; i < n; i++) begin
      adcValid = 1'b1;
      adcBeat = '{data: d0 + 16'(i), sol: i == 0, eol: i == n - 1, sof: fst && i == 0};
      while (!adcReady) @(negedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task automatic send_frame(input int ln, input int n);
    for (int y = 0; y < ln; y++) send_line(n, y == 0, 16'h00f0 + 16'(16 * y));
    adcValid = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wait_out(input int n);
    for (int k = 0; k < 2000 && pipe_sink_i.cnt < base + n; k++) @(negedge clk_sys);
    chk("beat count", 16'(base + n), 16'(pipe_sink_i.cnt));
  endtask
  task automatic start(input logic [2:0] s, input logic m, input logic sl);
    patSel = s;
    mirSel = m;
    slow = sl;
    base = pipe_sink_i.cnt;
    @(negedge clk_sys);
  endtask
  task automatic t_video;
    start(`PAT_OFF, `MIRROR_OFF, 1'b1);
    send_frame(2, 5);
    wait_out(10);
    for (int k = 0; k < 10; k++) begin
      chk("video data", 16'h00f0 + 16'(16 * (k / 5) + k % 5), got(k).data); // Sensor path
      chk("sol mark", 16'(k % 5 == 0), 16'(got(k).sol)); // Line start
      chk("sof mark", 16'(k == 0), 16'(got(k).sof)); // Frame start
    end
    $display("test video done");
  endtask
  task automatic t_mirror;
    int t0;
    start(`PAT_OFF, `MIRROR_ON, 1'b0);
    stall = 1'b1;
    fork
      send_frame(4, 16);
      begin
        repeat (120) @(negedge clk_sys);
        chk("input refused", 16'h0000, 16'(adcReady));
        stall = 1'b0;
      end
    join
    wait_out(64);
    for (int k = 0; k < 64; k++) begin
      chk("mirror data", 16'h00ff + 16'(16 * (k / 16) - k % 16), got(k).data); // Reversed lines
      chk("mirror eol", 16'(k % 16 == 15), 16'(got(k).eol)); // Line end
    end
    base = pipe_sink_i.cnt;
    t0 = cyc;
    send_frame(3, 16);
    chk("full rate", 16'h0001, 16'(cyc - t0 <= 60)); // No rate loss
    wait_out(48);
    $display("test mirror done");
  endtask
  task automatic t_ramps;
    start(`PAT_HRAMP, `MIRROR_OFF, 1'b0);
    send_frame(2, 16);
    wait_out(32);
    for (int k = 0; k < 32; k++) chk("hramp", 16'(k % 8), got(k).data & MSK); // Pixel steps
    start(`PAT_VRAMP, `MIRROR_OFF, 1'b1);
    send_frame(10, 2);
    wait_out(20);
    for (int k = 0; k < 20; k++) chk("vramp", 16'((k / 2) % 8), got(k).data & MSK); // Line steps
    $display("test ramps done");
  endtask
  task automatic t_moving;
    logic [15:0] b;
    start(`PAT_DRAMP, `MIRROR_OFF, 1'b0);
    send_frame(3, 3);
    send_frame(3, 3);
    wait_out(18);
    b = got(0).data;
    for (int k = 0; k < 18; k++) chk("diag", (b + 16'(k / 9 + k % 9 / 3 + k % 3)) & MSK, got(k).data & MSK);
    start(`PAT_PURITY, `MIRROR_OFF, 1'b1);
    send_frame(2, 3);
    send_frame(2, 3);
    wait_out(12);
    b = got(0).data;
    for (int k = 0; k < 12; k++) chk("purity", (b + 16'(k / 6)) & MSK, got(k).data & MSK); // Flat field
    $display("test moving done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    chk("reset valid", 16'h0000, 16'(outValid));
    chk("reset ready", 16'h0001, 16'(adcReady));
    chk("reset beat", 16'h0000, outBeat.data);
    rst_n = 1'b1;
    t_video();
    t_mirror();
    t_ramps();
    t_moving();
    summarize();
  end
endmodule
